// ### verilog/edb_defs.svh
/*
 * constants of the external data-memory bus: widths, window top and maximum size,
 * write timing counts.
 * assumes inclusion by bare name from the package and design files.
 */
`ifndef EDB_DEFS_SVH
`define EDB_DEFS_SVH

`define EDB_ADDR_W        16
`define EDB_DATA_W        16
`define EDB_WIN_TOP       16'hffff
`define EDB_WIN_MAX       16'h8000
`define EDB_WR_MIN_CYC    2
`define EDB_WAIT_W        4
`define EDB_GWIN_W        16

`endif

// ### verilog/edb_pkg.sv
/*
 * types of the external data-memory bus block.
 * assumes edb_defs.svh is reachable on the include path.
 */
`include "edb_defs.svh"

package edb_pkg;

    typedef struct packed {
        logic                   write;
        logic [`EDB_ADDR_W-1:0] addr;
        logic [`EDB_DATA_W-1:0] wdata;
    } edb_req_t;

    typedef struct packed {
        logic                   dataSpaceSelectN;
        logic                   accessStrobeN;
        logic                   readStrobeN;
        logic                   writeStrobeN;
        logic                   globalBusRequestN;
    } edb_ctl_t;

    typedef enum logic [2:0] {
        EDB_IDLE,
        EDB_RD,
        EDB_WR_LEAD,
        EDB_WR_HOLD,
        EDB_WR_TAIL,
        EDB_HANDOFF
    } edb_state_t;

endpackage

// ### verilog/edb_window_hit.sv
/*
 * global overlay window decode: an address hits when it lies in the top
 * windowSize words of the data space.
 * assumes the size is already clamped to the maximum window.
 */
`timescale 1ns/1ns
`include "edb_defs.svh"

module edb_window_hit
    import edb_pkg::*;
(
    input  wire logic [`EDB_ADDR_W-1:0] addr,
    input  wire logic [`EDB_GWIN_W-1:0] windowSize,
    output logic                        hit
);
    logic [`EDB_ADDR_W:0] base;

    // top minus size plus one; a zero size gives an empty window
    always_comb begin
        base = {1'b0, `EDB_WIN_TOP} - {1'b0, windowSize} + 17'h00001;
        hit  = (windowSize != 16'h0000) && ({1'b0, addr} >= base);
    end
endmodule

// ### verilog/edb_bus_if.sv
/*
 * external data-memory bus master with global paging and takeover.
 * assumes a core request port that holds its request until accepted,
 * and a board that resolves the three-signal pins into wires.
 */
`timescale 1ns/1ns
`include "edb_defs.svh"

// Summary of operation
// [RL1] reaches 64K words of off-chip local data memory
// [RL2] drives 16-bit address bus and separate 16-bit data bus
// [RL3] data-space select low on every off-chip data access
// [RL4] access strobe low throughout each external access
// [RL5] read strobe released before device drives data for a write
// [RL6] board gates select with strobe for RAM lacking output enable
// [RL7] writes last two cycles minimum, strobe half-cycle inset each end; here three cycles minimum, strobe inset one cycle each end
// [RL8] programmable wait states lengthen writes beyond two cycles
// [RL9] window size maps up to 32K global words downward from top
// [RL10] global bus request low on accesses inside the overlay window
// [RL11] control outputs identical on global and local accesses
// [RL12] access stays open until ready input is high
// [RL13] takeover request low is answered by takeover grant low
// [RL14] acquire acknowledge low while grant low acknowledges request
// [RL15] arbiter holds host not-ready while requesting takeover
// [RL16] arbiter transfers only after the grant is seen
// [RL17] board decodes I/O port address into device chip selects
// [RL18] buses and controls released to high impedance while granted
module edb_bus_if
    import edb_pkg::*;
#(
    parameter int WAIT_W = `EDB_WAIT_W
)
(
    input  wire logic                   clk_sys,
    input  wire logic                   resetn,
    input  wire edb_req_t               coreReq,
    input  wire logic                   coreReqValid,
    output logic                        coreReqReady,
    output logic [`EDB_DATA_W-1:0]      coreRdata,
    output logic                        coreRdValid,
    input  wire logic [WAIT_W-1:0]      writeWaits,
    input  wire logic [`EDB_GWIN_W-1:0] globalWindowSize,
    output logic [`EDB_ADDR_W-1:0]      addrOut,
    output logic                        addrOe,
    output logic [`EDB_DATA_W-1:0]      dataOut,
    output logic                        dataOe,
    input  wire logic [`EDB_DATA_W-1:0] dataIn,
    output edb_ctl_t                    ctlOut,
    output logic                        ctlOe,
    input  wire logic                   ready,
    input  wire logic                   takeoverRequestN,
    output logic                        takeoverGrantN,
    output logic                        acquireAcknowledgeN
);
    edb_state_t              state_q;
    logic [WAIT_W-1:0]       waitCnt_q;
    logic [`EDB_GWIN_W-1:0]  winSize;
    logic                    hit;
    logic                    startOk;
    logic                    accStart;
    logic                    rdDone;
    logic                    wrRelease;
    logic                    accEnd;
    logic                    grantNow;
    logic                    selectN_q;
    logic                    strobeN_q;
    logic                    readN_q;
    logic                    writeN_q;
    logic                    pageReqN_q;

    // sizes above the maximum window are clamped rather than wrapped
    assign winSize = (globalWindowSize > `EDB_WIN_MAX) ?
                     `EDB_WIN_MAX : globalWindowSize; // [RL9]

    edb_window_hit u_hit (
        .addr       (coreReq.addr),
        .windowSize (winSize),
        .hit        (hit)
    );

    // a pending takeover wins over a new core access
    assign startOk = coreReqValid && takeoverRequestN;

    // access decodes shared by several output registers
    // take: idle, core asking, no takeover pending
    function automatic logic takeStart(input edb_state_t s,
                                       input logic       ok);
        return (s == EDB_IDLE) && ok;
    endfunction

    // read ends on the first ready seen in the read state
    function automatic logic readDone(input edb_state_t s,
                                      input logic       rdy);
        return (s == EDB_RD) && rdy;
    endfunction

    // write strobe rises only once waits are spent and memory is ready
    function automatic logic writeRelease(input edb_state_t        s,
                                          input logic [WAIT_W-1:0] cnt,
                                          input logic              rdy);
        return (s == EDB_WR_HOLD) && (cnt == '0) && rdy;
    endfunction

    // grant holds only while the far master keeps asking
    function automatic logic granted(input edb_state_t s,
                                     input logic       reqN);
        return (s == EDB_HANDOFF) && !reqN;
    endfunction

    assign accStart  = takeStart(state_q, startOk);
    assign rdDone    = readDone(state_q, ready);
    assign wrRelease = writeRelease(state_q, waitCnt_q, ready);
    assign accEnd    = rdDone || (state_q == EDB_WR_TAIL);
    assign grantNow  = granted(state_q, takeoverRequestN);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_q <= EDB_IDLE;
        end else begin
            unique case (state_q)
                EDB_IDLE: begin
                    if (!takeoverRequestN) begin
                        state_q <= EDB_HANDOFF; // [RL13]
                    end else if (coreReqValid) begin
                        state_q <= coreReq.write ? EDB_WR_LEAD : EDB_RD;
                    end
                end
                EDB_RD: begin
                    if (ready) begin
                        state_q <= EDB_IDLE; // [RL12]
                    end
                end
                EDB_WR_LEAD: state_q <= EDB_WR_HOLD; // [RL7]
                EDB_WR_HOLD: begin
                    if (waitCnt_q == '0 && ready) begin
                        state_q <= EDB_WR_TAIL; // [RL8] [RL12]
                    end
                end
                EDB_WR_TAIL: state_q <= EDB_IDLE; // [RL7]
                EDB_HANDOFF: begin
                    if (takeoverRequestN) begin
                        state_q <= EDB_IDLE;
                    end
                end
                default: state_q <= EDB_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            waitCnt_q <= '0;
        end else if (state_q == EDB_IDLE && startOk && coreReq.write) begin
            waitCnt_q <= writeWaits; // [RL8]
        end else if (state_q == EDB_WR_HOLD && waitCnt_q != '0) begin
            waitCnt_q <= waitCnt_q - 1'b1;
        end
    end

    // address and data are captured once, when the access is taken
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            addrOut <= '0;
        end else if (accStart) begin
            addrOut <= coreReq.addr; // [RL1] [RL2]
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            dataOut <= '0;
        end else if (accStart) begin
            dataOut <= coreReq.wdata; // [RL2]
        end
    end

    // select and strobe move together, so a board can gate one by the other
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            selectN_q <= 1'b1;
        end else if (accStart) begin
            selectN_q <= 1'b0; // [RL3] [RL11]
        end else if (accEnd) begin
            selectN_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            strobeN_q <= 1'b1;
        end else if (accStart) begin
            strobeN_q <= 1'b0; // [RL4] [RL11]
        end else if (accEnd) begin
            strobeN_q <= 1'b1; // [RL12]
        end
    end

    // read strobe stays high on writes, so memory never fights our drivers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            readN_q <= 1'b1;
        end else if (accStart) begin
            readN_q <= coreReq.write; // [RL5]
        end else if (accEnd) begin
            readN_q <= 1'b1;
        end
    end

    // write strobe is inset one cycle from each end of the access
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            writeN_q <= 1'b1;
        end else if (accStart) begin
            writeN_q <= 1'b1;
        end else if (state_q == EDB_WR_LEAD) begin
            writeN_q <= 1'b0; // [RL7]
        end else if (wrRelease) begin
            writeN_q <= 1'b1; // [RL7] [RL8]
        end else if (accEnd) begin
            writeN_q <= 1'b1;
        end
    end

    // page request is fixed for the whole access, local or global alike
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pageReqN_q <= 1'b1;
        end else if (accStart) begin
            pageReqN_q <= !hit; // [RL9] [RL10]
        end else if (accEnd) begin
            pageReqN_q <= 1'b1;
        end
    end

    assign ctlOut = '{dataSpaceSelectN:  selectN_q,
                      accessStrobeN:     strobeN_q,
                      readStrobeN:       readN_q,
                      writeStrobeN:      writeN_q,
                      globalBusRequestN: pageReqN_q};

    // data drivers turn on only for writes, with read strobe already high
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            dataOe <= 1'b0;
        end else if (accStart) begin
            dataOe <= coreReq.write; // [RL5]
        end else if (accEnd) begin
            dataOe <= 1'b0;
        end
    end

    // release pins while another master owns the bus
    // takeover waits for idle: long writes delay the grant
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            addrOe <= 1'b1;
        end else begin
            addrOe <= state_q != EDB_HANDOFF; // [RL18]
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctlOe <= 1'b1;
        end else begin
            ctlOe <= state_q != EDB_HANDOFF; // [RL18]
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            takeoverGrantN <= 1'b1;
        end else begin
            takeoverGrantN <= !grantNow; // [RL13] [RL16]
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            acquireAcknowledgeN <= 1'b1;
        end else begin
            acquireAcknowledgeN <= !grantNow; // [RL14]
        end
    end

    // core handshake pulses last one cycle each
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            coreReqReady <= 1'b0;
        end else begin
            coreReqReady <= accEnd;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            coreRdValid <= 1'b0;
        end else begin
            coreRdValid <= rdDone; // [RL12]
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            coreRdata <= '0;
        end else if (rdDone) begin
            coreRdata <= dataIn;
        end
    end
endmodule

// ### testbench/edb_bus_if_sva.sv
/* pin assertions of edb_bus_if; assumes binding to its ports by name */
`timescale 1ns/1ns
module edb_bus_if_chk
    import edb_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        resetn,
    input wire logic        coreRdValid,
    input wire logic [15:0] addrOut,
    input wire logic [15:0] globalWindowSize,
    input wire logic        addrOe,
    input wire logic        dataOe,
    input wire edb_ctl_t    ctlOut,
    input wire logic        ctlOe,
    input wire logic        ready,
    input wire logic        takeoverRequestN,
    input wire logic        takeoverGrantN,
    input wire logic        acquireAcknowledgeN
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // size 0 puts the base above ffff, so nothing hits
    // window is capped at 32K words
    wire logic [15:0] winEff  = (globalWindowSize > 16'h8000) ?
                                16'h8000 : globalWindowSize;
    wire logic [16:0] winBase = 17'h10000 - {1'b0, winEff};
    property p_sel;
        ctlOe |-> ctlOut.dataSpaceSelectN == ctlOut.accessStrobeN;
    endproperty
    a_sel: assert property (p_sel) else $error("select off strobe");
    property p_br;
        !ctlOut.accessStrobeN |->
            ctlOut.globalBusRequestN == ({1'b0, addrOut} < winBase);
    endproperty
    a_br: assert property (p_br) else $error("bus request wrong");
    property p_rdOff; !ctlOut.readStrobeN |-> !dataOe; endproperty
    a_rdOff: assert property (p_rdOff) else $error("read clash");
    property p_weFall;
        $fell(ctlOut.writeStrobeN) |->
            $past(ctlOut.accessStrobeN) == 1'b0 && dataOe;
    endproperty
    a_weFall: assert property (p_weFall) else $error("write lead");
    property p_rdHold;
        !ctlOut.readStrobeN |=> coreRdValid == $past(ready);
    endproperty
    a_rdHold: assert property (p_rdHold) else $error("ready skip");
    property p_grant;
        $fell(takeoverGrantN) |-> $past(takeoverRequestN) == 1'b0;
    endproperty
    a_grant: assert property (p_grant) else $error("grant unasked");
    property p_ack; acquireAcknowledgeN == takeoverGrantN; endproperty
    a_ack: assert property (p_ack) else $error("ack differs");
    property p_rel; !takeoverGrantN |-> !(addrOe | ctlOe | dataOe); endproperty
    a_rel: assert property (p_rel) else $error("bus not released");
    c_read: cover property (coreRdValid);
    c_write: cover property ($fell(ctlOut.writeStrobeN));
    c_grant: cover property ($fell(takeoverGrantN));
endmodule
bind edb_bus_if edb_bus_if_chk chk (
    .clk_sys             (clk_sys),
    .resetn              (resetn),
    .coreRdValid         (coreRdValid),
    .addrOut             (addrOut),
    .globalWindowSize    (globalWindowSize),
    .addrOe              (addrOe),
    .dataOe              (dataOe),
    .ctlOut              (ctlOut),
    .ctlOe               (ctlOe),
    .ready               (ready),
    .takeoverRequestN    (takeoverRequestN),
    .takeoverGrantN      (takeoverGrantN),
    .acquireAcknowledgeN (acquireAcknowledgeN)
);

// ### testbench/edb_sram_model.sv
/* static ram on the far side; assumes active-low controls, 256 words */
`timescale 1ns/1ns
module edb_sram_model
    import edb_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        slow,
    input  wire logic [15:0] addr,
    input  wire logic [15:0] wdata,
    input  wire edb_ctl_t    ctl,
    output logic      [15:0] rdata,
    output logic             ready
);
    logic [15:0] mem [0:255];
    logic [15:0] last = 16'h0000;
    logic        first = 1'b1;
    // drives only while select, strobe and read strobe are low
    wire logic   rdOn = !(ctl.dataSpaceSelectN | ctl.accessStrobeN
                          | ctl.readStrobeN);
    // released bus shows the inverse, not a stale value
    assign rdata = rdOn ? mem[addr[7:0]] : ~last;
    // slow part holds off the first cycle of each access
    assign ready = !(slow && first);
    always @(posedge clk_sys) begin
        first <= ctl.accessStrobeN;
        if (rdOn)
            last <= rdata;
        // decoded select gated with the write strobe, as board logic would
        if (!(ctl.dataSpaceSelectN | ctl.writeStrobeN))
            mem[addr[7:0]] <= wdata;
    end
endmodule

// ### testbench/external_data_memory_bus_tb.sv
/* bench of edb_bus_if with ram model; assumes the checker binds itself */
`timescale 1ns/1ns
module external_data_memory_bus_tb
    import edb_pkg::*;
;
    logic        clk_sys = 1'b0, resetn = 1'b0, valid = 1'b0;
    logic        slow = 1'b0, toReqN = 1'b1, eb;
    logic        reqRdy, rdV, addrOe, dataOe, ctlOe, ready, grantN, ackN;
    logic [3:0]  waits = 4'h0;
    logic [15:0] winSize = 16'h0000, rdata, addrOut, dataOut, dataIn, memOut;
    edb_req_t    req = '0;
    edb_ctl_t    ctl;
    int          miscompares = 0, tests_run = 0, cycles = 0;
    // write, addr, data, waits, window, bus request high, slow
    logic [54:0] rows [9] = '{
        {1'b1,16'h0010,16'ha5a5,4'h0,16'h0000,2'b10},
        {1'b0,16'h0010,16'ha5a5,4'h0,16'h0000,2'b10},
        {1'b1,16'hff00,16'h1234,4'h2,16'h0100,2'b00},
        {1'b1,16'hfeff,16'h5555,4'h1,16'h0100,2'b10},
        {1'b0,16'hff00,16'h1234,4'h0,16'h0100,2'b01},
        {1'b1,16'h8000,16'h0f0f,4'hf,16'h8000,2'b00},
        {1'b0,16'h8000,16'h0f0f,4'h0,16'h8000,2'b01},
        {1'b0,16'h8000,16'h0f0f,4'h0,16'h0000,2'b10},
        {1'b0,16'h7fff,16'h5555,4'h0,16'hffff,2'b10}};
    edb_bus_if DUT (.clk_sys(clk_sys), .resetn(resetn), .coreReq(req),
        .coreReqValid(valid), .coreReqReady(reqRdy), .coreRdata(rdata),
        .coreRdValid(rdV), .writeWaits(waits), .globalWindowSize(winSize),
        .addrOut(addrOut), .addrOe(addrOe), .dataOut(dataOut),
        .dataOe(dataOe), .dataIn(dataIn), .ctlOut(ctl), .ctlOe(ctlOe),
        .ready(ready), .takeoverRequestN(toReqN), .takeoverGrantN(grantN),
        .acquireAcknowledgeN(ackN));
    edb_sram_model ram (.clk_sys(clk_sys), .slow(slow), .addr(addrOut),
        .wdata(dataOut), .ctl(ctl), .rdata(memOut), .ready(ready));
    assign dataIn = dataOe ? dataOut : memOut;
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            results();
        end
    end
    task automatic check(input string what, input logic [15:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results();
        $display("compares %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // bus request is only seen while the strobe is low
    task automatic access(input logic [54:0] r);
        int   n, k;
        logic br;
        n = 0;
        br = 1'bx;
        @(posedge clk_sys);
        #1;
        {req.write, req.addr, req.wdata, waits, winSize, eb, slow} = r;
        valid = 1'b1;
        for (k = 0; k < 40 && reqRdy !== 1'b1; k++) begin
            @(posedge clk_sys);
            #1;
            if (ctl.accessStrobeN === 1'b0) begin
                n++;
                br = ctl.globalBusRequestN;
            end
        end
        valid = 1'b0;
        check("strobe cycles", req.write ? 16'(3 + waits) : 16'(1 + slow),
              16'(n));
        check("bus request", {15'h0, eb}, {15'h0, br});
        if (!req.write) begin
            check("read data", req.wdata, rdata);
            check("read valid", 16'h0001, {15'h0, rdV});
        end
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        #1 resetn = 1'b1;
        foreach (rows[i])
            access(rows[i]);
        @(posedge clk_sys);
        #1 toReqN = 1'b0;
        valid = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        check("grant", 16'h0, {14'h0, grantN, ackN});
        check("release", 16'h0, {13'h0, addrOe, ctlOe, dataOe});
        check("refused", 16'h0, {15'h0, reqRdy});
        toReqN = 1'b1;
        valid = 1'b0;
        access(rows[7]);
        resetn = 1'b0;
        #2;
        check("reset ctl", 16'h001f, {11'h0, ctl});
        check("reset oe", 16'h001e, {11'h0, grantN, ackN, addrOe, ctlOe,
              dataOe});
        @(posedge clk_sys);
        #1 resetn = 1'b1;
        access(rows[1]);
        results();
    end
endmodule
